/* include/niu_pkg.sv */
// constants and types shared by the indication and interrupt unit
package niu_pkg;

    // ************************************************************
    // register access
    // ************************************************************
    localparam int          ADDR_W        = 5;
    localparam int          DATA_W        = 16;
    localparam int          BANK_W        = 3;
    localparam logic [4:0]  OFS_IRQ_MASK  = 5'h0A;
    localparam logic [4:0]  OFS_IND_MASK  = 5'h0C;
    localparam logic [4:0]  OFS_STATUS    = 5'h0E;
    localparam logic [4:0]  OFS_AUTO_VIEW = 5'h1E;
    localparam logic [2:0]  BANK_MASKS    = 3'h5;

    // ************************************************************
    // status word layout
    // ************************************************************
    localparam int          B_LATCH       = 0;
    localparam int          B_FAULT       = 1;
    localparam int          B_TXD         = 2;
    localparam int          B_RXD         = 4;
    localparam int          B_RXP         = 5;
    localparam int          B_SWI         = 6;
    localparam int          B_CNT         = 7;
    localparam int          B_LNK         = 8;
    localparam int          B_DND         = 9;
    localparam int          B_UPD         = 10;
    localparam int          BANK_LSB      = 13;
    localparam logic [15:0] SRC_BITS      = 16'h07F6;
    localparam logic [15:0] ACK_BITS      = 16'h0761;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [15:0] MASK_RST      = 16'h0000;
    localparam logic [15:0] STATUS_RST    = 16'h0000;
    localparam logic [2:0]  BANK_RST      = 3'h0;

    // ************************************************************
    // commands: opcode in [15:11], argument in [10:0]
    // ************************************************************
    localparam int          CMD_UPDN_BIT  = 6;
    typedef enum logic [4:0] {
        CMD_GLOBAL_RST    = 5'h00,
        CMD_SEL_BANK      = 5'h01,
        CMD_ACK_IRQ       = 5'h0D,
        CMD_LOAD_IRQ_MASK = 5'h0E,
        CMD_LOAD_IND_MASK = 5'h0F
    } niu_cmd_t;

endpackage

/* include/niu_flag_if.sv */
// set, clear and state of the sticky status flags
`timescale 1ns/10ps
interface niu_flag_if #(parameter int W = 16);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic [W-1:0] flags;
    modport owner (input set, input clr, output flags);
    modport user  (output set, output clr, input flags);
endinterface

/* src/niu_flag_bank.sv */
// sticky status flags; a set in the same cycle as a clear wins
`timescale 1ns/10ps
module niu_flag_bank
    import niu_pkg::*;
#(
    parameter int W = 16
)
(
    // clock and reset
    input  wire logic   i_sys_clk,
    input  wire logic   i_rst_n,
    // flag carrier
    niu_flag_if.owner   fl
);

    logic [W-1:0] flags_r;
    logic [W-1:0] flags_nxt;

    assign flags_nxt = (flags_r & ~fl.clr) | fl.set;
    assign fl.flags  = flags_r;

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            flags_r <= W'(STATUS_RST);
        else
            flags_r <= flags_nxt;
    end

    chk_set_wins_clear: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (fl.set != '0) |=> ((flags_r & $past(fl.set)) == $past(fl.set)))
        else $error("flag set lost against a clear");

    chk_clear_selected: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        1'b1 |=> (flags_r == (($past(flags_r) & ~$past(fl.clr)) | $past(fl.set))))
        else $error("flags changed outside the selected bits");

endmodule

/* src/niu_top.sv */
// indication and interrupt unit: status word, two-level masks, bus interrupt
//
// Functional notes
// - an indication latches only where its indication mask bit is set
// - visible status bit drives bus interrupt only where its irq mask bit is set
// - pending latch bit 0 sets whenever any enabled interrupt is asserted
// - pending latch clears only by the ack command with bit 0 selected
// - bus fault flag stays until a global reset command with argument bit 6 clear clears it
// - transmit done flag clears on a write to the transmit result register
// - receive done flag clears automatically as the upload logic consumes packets
// - software, download and upload flags clear only by matching ack bits; partial also clears on receive done
// - counter near full flag clears when the statistics counters are read
// - link change flag clears when the negotiation expansion register is read
// - indication mask at bank 5 offset C is read only; loaded by command
// - interrupt mask at bank 5 offset A is read only; loaded by command
// - both masks are all zeros after reset
// - any read of the auto-clearing status view clears the whole interrupt mask
// - status word readable at offset E in every bank
// - bits 15:13 show the bank of the accessing port; PCI and SMBus kept apart
// - bits 1 to 10 except bit 3 are the sources, each maskable by both masks
// - all status bits clear on reset
// - bus interrupt stays asserted while any enabled interrupt is pending
// - bus interrupt is the OR of doubly masked sources; the latch sets from that OR
// - bus fault bit 1 sets on a target abort or master abort
`timescale 1ns/10ps
module niu_top
    import niu_pkg::*;
(
    // clock and reset
    input  wire logic               i_sys_clk,
    input  wire logic               i_resetn,
    // register access port
    input  wire logic               i_reg_rd,
    input  wire logic               i_reg_wr,
    input  wire logic               i_reg_smb,
    input  wire logic [ADDR_W-1:0]  i_reg_addr,
    input  wire logic [DATA_W-1:0]  i_reg_wdata,
    // event sources
    input  wire logic               i_bus_abort,
    input  wire logic               i_tx_done,
    input  wire logic               i_rx_done,
    input  wire logic               i_rx_partial,
    input  wire logic               i_sw_irq,
    input  wire logic               i_cnt_near_full,
    input  wire logic               i_link_change,
    input  wire logic               i_dn_done,
    input  wire logic               i_up_done,
    // hardware acknowledges
    input  wire logic               i_txres_wr,
    input  wire logic               i_upload_consumed,
    input  wire logic               i_stats_read,
    input  wire logic               i_negexp_read,
    // outputs
    output logic [DATA_W-1:0]       o_reg_rdata,
    output logic                    o_pci_irq
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [15:0] bit_at(input int pos, input logic en);
        logic [15:0] v;
        v = 16'h0000;
        v[pos] = en;
        return v;
    endfunction

    function automatic logic [15:0] visible(input logic [15:0] fl,
                                            input logic [15:0] ind);
        return (fl & ind & SRC_BITS) | (fl & bit_at(B_LATCH, 1'b1));
    endfunction

    function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                     input logic [4:0] ofs);
        return (a == ADDR_W'(ofs));
    endfunction

    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta_r;
    logic rst_sync_r;
    logic rst_n;

    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    assign rst_n = rst_sync_r;

    // ************************************************************
    // command decode (a write at the status offset is a command)
    // ************************************************************
    logic           cmd_wr;
    niu_cmd_t       cmd_op;
    logic [10:0]    cmd_arg;
    logic           is_ack;
    logic           is_ld_ind;
    logic           is_ld_irq;
    logic           is_sel;
    logic           is_grst;
    logic [15:0]    arg16;
    logic [15:0]    ack_sel;
    logic           fault_clr;
    logic           auto_rd;

    assign cmd_wr    = i_reg_wr && addr_is(i_reg_addr, OFS_STATUS);
    assign cmd_op    = niu_cmd_t'(i_reg_wdata[15:11]);
    assign cmd_arg   = i_reg_wdata[10:0];
    assign arg16     = {5'h00, cmd_arg};
    assign is_ack    = cmd_wr && (cmd_op == CMD_ACK_IRQ);
    assign is_ld_ind = cmd_wr && (cmd_op == CMD_LOAD_IND_MASK);
    assign is_ld_irq = cmd_wr && (cmd_op == CMD_LOAD_IRQ_MASK);
    assign is_sel    = cmd_wr && (cmd_op == CMD_SEL_BANK);
    assign is_grst   = cmd_wr && (cmd_op == CMD_GLOBAL_RST);
    assign ack_sel   = is_ack ? (arg16 & ACK_BITS) : 16'h0000;
    assign fault_clr = is_grst && !cmd_arg[CMD_UPDN_BIT];
    assign auto_rd   = i_reg_rd && addr_is(i_reg_addr, OFS_AUTO_VIEW);

    // ************************************************************
    // bank selections, one per access port
    // ************************************************************
    logic [2:0] pci_bank_r;
    logic [2:0] smb_bank_r;
    logic [2:0] pci_bank_nxt;
    logic [2:0] smb_bank_nxt;
    logic [2:0] cur_bank;

    assign pci_bank_nxt = (is_sel && !i_reg_smb) ? cmd_arg[2:0] : pci_bank_r;
    assign smb_bank_nxt = (is_sel && i_reg_smb) ? cmd_arg[2:0] : smb_bank_r;
    assign cur_bank     = i_reg_smb ? smb_bank_r : pci_bank_r;

    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pci_bank_r <= BANK_RST;
            smb_bank_r <= BANK_RST;
        end
        else
        begin
            pci_bank_r <= pci_bank_nxt;
            smb_bank_r <= smb_bank_nxt;
        end
    end

    // ************************************************************
    // masks, loaded only by command; an auto view read also clears the interrupt mask
    // ************************************************************
    logic [15:0] ind_mask_r;
    logic [15:0] irq_mask_r;
    logic [15:0] ind_mask_nxt;
    logic [15:0] irq_mask_nxt;

    assign ind_mask_nxt = is_ld_ind ? (arg16 & SRC_BITS) : ind_mask_r;
    assign irq_mask_nxt = is_ld_irq ? (arg16 & SRC_BITS) :
                          auto_rd   ? MASK_RST : irq_mask_r;

    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ind_mask_r <= MASK_RST;
            irq_mask_r <= MASK_RST;
        end
        else
        begin
            ind_mask_r <= ind_mask_nxt;
            irq_mask_r <= irq_mask_nxt;
        end
    end

    // ************************************************************
    // status flags
    // ************************************************************
    niu_flag_if #(.W(16)) flg ();

    niu_flag_bank #(
        .W          (16)
    ) u_flags (
        .i_sys_clk  (i_sys_clk),
        .i_rst_n    (rst_n),
        .fl         (flg)
    );

    logic [15:0] ev_vec;
    logic [15:0] hw_clr;
    logic [15:0] vis;
    logic        any_irq;

    assign ev_vec = bit_at(B_FAULT, i_bus_abort)     | bit_at(B_TXD, i_tx_done)
                  | bit_at(B_RXD, i_rx_done)         | bit_at(B_RXP, i_rx_partial)
                  | bit_at(B_SWI, i_sw_irq)          | bit_at(B_CNT, i_cnt_near_full)
                  | bit_at(B_LNK, i_link_change)     | bit_at(B_DND, i_dn_done)
                  | bit_at(B_UPD, i_up_done);

    // a complete packet also ends the partial indication
    assign hw_clr = bit_at(B_FAULT, fault_clr)
                  | bit_at(B_TXD, i_txres_wr)
                  | bit_at(B_RXD, i_upload_consumed)
                  | bit_at(B_RXP, i_rx_done)
                  | bit_at(B_CNT, i_stats_read)
                  | bit_at(B_LNK, i_negexp_read || auto_rd);

    assign vis      = visible(flg.flags, ind_mask_r);
    assign any_irq  = |(vis & irq_mask_r & SRC_BITS);
    assign flg.set  = (ev_vec & ind_mask_r & SRC_BITS)
                    | bit_at(B_LATCH, any_irq);
    assign flg.clr  = ack_sel | hw_clr;

    // ************************************************************
    // read data and interrupt line
    // ************************************************************
    logic [15:0] status_word;
    logic        in_mask_bank;
    logic [15:0] rdata_sel;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic        irq_r;

    assign status_word  = {cur_bank, 2'b00, vis[10:0]};
    assign in_mask_bank = (cur_bank == BANK_MASKS);
    assign rdata_sel    = (addr_is(i_reg_addr, OFS_STATUS) ||
                           addr_is(i_reg_addr, OFS_AUTO_VIEW))          ? status_word :
                          (in_mask_bank && addr_is(i_reg_addr, OFS_IRQ_MASK)) ? irq_mask_r :
                          (in_mask_bank && addr_is(i_reg_addr, OFS_IND_MASK)) ? ind_mask_r :
                          16'h0000;
    assign rdata_nxt    = i_reg_rd ? rdata_sel : rdata_r;

    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_r <= 16'h0000;
            irq_r   <= 1'b0;
        end
        else
        begin
            rdata_r <= rdata_nxt;
            irq_r   <= any_irq;
        end
    end

    assign o_reg_rdata = rdata_r;
    assign o_pci_irq   = irq_r;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking chk_cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence ack_latch_s;
        is_ack && cmd_arg[B_LATCH];
    endsequence

    sequence masked_pending_s;
        |(vis & irq_mask_r & SRC_BITS);
    endsequence

    chk_ind_gate: assert property (
        (vis & ~ind_mask_r & SRC_BITS) == 16'h0000)
        else $error("indication visible while its mask bit is clear");

    chk_irq_gate: assert property (
        !(|(vis & irq_mask_r)) |=> !o_pci_irq)
        else $error("bus interrupt without an enabled source");

    chk_irq_follow: assert property (
        masked_pending_s |=> o_pci_irq)
        else $error("bus interrupt not raised for enabled source");

    chk_latch_set: assert property (
        masked_pending_s |=> flg.flags[B_LATCH])
        else $error("pending latch not set");

    chk_latch_hold: assert property (
        (flg.flags[B_LATCH] && !(is_ack && cmd_arg[B_LATCH])) |=> flg.flags[B_LATCH])
        else $error("pending latch cleared without acknowledge");

    chk_latch_ack: assert property (
        (ack_latch_s ##0 !(|(vis & irq_mask_r & SRC_BITS))) |=> !flg.flags[B_LATCH])
        else $error("pending latch survived acknowledge");

    chk_fault_hold: assert property (
        (flg.flags[B_FAULT] && !fault_clr) |=> flg.flags[B_FAULT])
        else $error("bus fault flag lost without reset command");

    chk_tx_ack: assert property (
        (i_txres_wr && !(i_tx_done && ind_mask_r[B_TXD])) |=> !flg.flags[B_TXD])
        else $error("transmit done not cleared by result write");

    chk_rx_auto: assert property (
        (i_upload_consumed && !(i_rx_done && ind_mask_r[B_RXD])) |=> !flg.flags[B_RXD])
        else $error("receive done not cleared by upload");

    chk_ack_only: assert property (
        (flg.flags[B_DND] && !(is_ack && cmd_arg[B_DND])) |=> flg.flags[B_DND])
        else $error("download done cleared without acknowledge");

    chk_stats_clear: assert property (
        (i_stats_read && !(i_cnt_near_full && ind_mask_r[B_CNT])) |=> !flg.flags[B_CNT])
        else $error("counter near full not cleared by statistics read");

    chk_link_clear: assert property (
        (i_negexp_read && !(i_link_change && ind_mask_r[B_LNK])) |=> !flg.flags[B_LNK])
        else $error("link change not cleared by expansion read");

    chk_mask_reset: assert property (
        $rose(rst_n) |-> (ind_mask_r == MASK_RST && irq_mask_r == MASK_RST))
        else $error("masks not clear after reset");

    chk_auto_clear: assert property (
        auto_rd |=> (irq_mask_r == 16'h0000) ##1 (irq_mask_r == 16'h0000 || $past(is_ld_irq)))
        else $error("auto view read did not clear interrupt mask");

    chk_bank_view: assert property (
        (i_reg_rd && addr_is(i_reg_addr, OFS_STATUS))
            |=> (o_reg_rdata[15:13] == $past(cur_bank)))
        else $error("status word shows the wrong bank");

    chk_reserved_zero: assert property (
        (i_reg_rd && addr_is(i_reg_addr, OFS_STATUS)) |=> (o_reg_rdata[12:11] == 2'b00
            && o_reg_rdata[3] == 1'b0))
        else $error("reserved status bit reads nonzero");

endmodule

/* tb/niu_host_model.sv */
// host driver model issuing register reads, writes and commands
`timescale 1ns/10ps
module niu_host_model
    import niu_pkg::*;
(
    // clock
    input  wire logic               i_sys_clk,
    // register access port
    input  wire logic [DATA_W-1:0]  i_reg_rdata,
    output logic                    o_reg_rd,
    output logic                    o_reg_wr,
    output logic                    o_reg_smb,
    output logic [ADDR_W-1:0]       o_reg_addr,
    output logic [DATA_W-1:0]       o_reg_wdata
);
    initial
    begin
        o_reg_rd    = 1'b0;
        o_reg_wr    = 1'b0;
        o_reg_smb   = 1'b0;
        o_reg_addr  = 5'h1F;
        o_reg_wdata = 16'hFFFF;
    end

    // ************************************************************
    // bus cycles; address and data are scrambled once released
    // ************************************************************
    task automatic read_reg(input logic [4:0] a, input logic s, output logic [15:0] d);
        @(posedge i_sys_clk);
        o_reg_rd   <= 1'b1;
        o_reg_addr <= a;
        o_reg_smb  <= s;
        @(posedge i_sys_clk);
        o_reg_rd   <= 1'b0;
        o_reg_addr <= ~a;
        #1;
        d = i_reg_rdata;
    endtask

    task automatic write_reg(input logic [4:0] a, input logic s, input logic [15:0] d);
        @(posedge i_sys_clk);
        o_reg_wr    <= 1'b1;
        o_reg_addr  <= a;
        o_reg_smb   <= s;
        o_reg_wdata <= d;
        @(posedge i_sys_clk);
        o_reg_wr    <= 1'b0;
        o_reg_addr  <= ~a;
        o_reg_wdata <= ~d;
    endtask

    // masks and acknowledges change through explicit commands; an auto view read also clears the interrupt mask
    task automatic cmd(input niu_cmd_t op, input logic [10:0] arg, input logic s);
        write_reg(OFS_STATUS, s, {op, arg});
    endtask
endmodule

/* tb/niu_top_bench.sv */
// self-checking bench for the indication and interrupt unit
`timescale 1ns/10ps
module niu_top_bench
    import niu_pkg::*;
;
    logic               sys_clk = 1'b0;
    logic               resetn  = 1'b1;
    logic [12:0]        ev      = 13'h0000;
    logic               reg_rd;
    logic               reg_wr;
    logic               reg_smb;
    logic [ADDR_W-1:0]  reg_addr;
    logic [DATA_W-1:0]  reg_wdata;
    logic [DATA_W-1:0]  reg_rdata;
    logic               pci_irq;
    logic [15:0]        exp_st;
    logic [15:0]        bk;
    int                 n_fail = 0;
    int                 samples_checked = 0;

    always #25 sys_clk = ~sys_clk;

    niu_top niu_top_inst (
        .i_sys_clk         (sys_clk),
        .i_resetn          (resetn),
        .i_reg_rd          (reg_rd),
        .i_reg_wr          (reg_wr),
        .i_reg_smb         (reg_smb),
        .i_reg_addr        (reg_addr),
        .i_reg_wdata       (reg_wdata),
        .i_bus_abort       (ev[0]),
        .i_tx_done         (ev[1]),
        .i_rx_done         (ev[2]),
        .i_rx_partial      (ev[3]),
        .i_sw_irq          (ev[4]),
        .i_cnt_near_full   (ev[5]),
        .i_link_change     (ev[6]),
        .i_dn_done         (ev[7]),
        .i_up_done         (ev[8]),
        .i_txres_wr        (ev[9]),
        .i_upload_consumed (ev[10]),
        .i_stats_read      (ev[11]),
        .i_negexp_read     (ev[12]),
        .o_reg_rdata       (reg_rdata),
        .o_pci_irq         (pci_irq)
    );

    niu_host_model niu_host_model_inst (
        .i_sys_clk   (sys_clk),
        .i_reg_rdata (reg_rdata),
        .o_reg_rd    (reg_rd),
        .o_reg_wr    (reg_wr),
        .o_reg_smb   (reg_smb),
        .o_reg_addr  (reg_addr),
        .o_reg_wdata (reg_wdata)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk_rd(input logic [4:0] a, input logic s, input logic [15:0] e);
        logic [15:0] d;
        niu_host_model_inst.read_reg(a, s, d);
        samples_checked++;
        if (d !== e)
        begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, d, e);
        end
    endtask

    task automatic chk_irq(input logic e);
        repeat (3) @(posedge sys_clk);
        #1;
        samples_checked++;
        if (pci_irq !== e)
        begin
            n_fail++;
            $display("BAD t=%0t irq %h exp %h", $time, pci_irq, e);
        end
    endtask

    task automatic pulse(input logic [12:0] v);
        @(posedge sys_clk);
        ev <= v;
        @(posedge sys_clk);
        ev <= 13'h0000;
    endtask

    task automatic cmd(input niu_cmd_t op, input logic [10:0] arg, input logic s);
        niu_host_model_inst.cmd(op, arg, s);
    endtask

    // one clearing action, then the status word is read back
    task automatic clr_step(input niu_cmd_t op, input logic [12:0] v, input logic [10:0] arg,
                            input logic [15:0] clr);
        if (v != 13'h0000)
            pulse(v);
        else
            cmd(op, arg, 1'b0);
        exp_st = exp_st & ~clr;
        chk_rd(OFS_STATUS, 1'b0, exp_st);
    endtask

    // ************************************************************
    // watchdog
    // ************************************************************
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        conclude();
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial
    begin
        // a real falling edge at time zero, so every flop and check starts in reset
        resetn <= 1'b0;
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (5) @(posedge sys_clk);
        bk = {BANK_MASKS, 13'h0000};
        chk_rd(OFS_STATUS, 1'b0, STATUS_RST);
        chk_rd(OFS_IRQ_MASK, 1'b0, 16'h0000);
        cmd(CMD_SEL_BANK, 11'h005, 1'b0);
        chk_rd(OFS_IRQ_MASK, 1'b0, MASK_RST);
        chk_rd(OFS_IND_MASK, 1'b0, MASK_RST);
        chk_rd(OFS_STATUS, 1'b0, bk);
        niu_host_model_inst.write_reg(OFS_IRQ_MASK, 1'b0, 16'hFFFF);
        niu_host_model_inst.write_reg(OFS_IND_MASK, 1'b0, 16'hFFFF);
        chk_rd(OFS_IRQ_MASK, 1'b0, 16'h0000);
        chk_rd(OFS_IND_MASK, 1'b0, 16'h0000);
        // only transmit done may latch
        cmd(CMD_LOAD_IND_MASK, 11'h004, 1'b0);
        pulse(13'h01FF);
        cmd(CMD_LOAD_IND_MASK, 11'h7FF, 1'b0);
        chk_rd(OFS_IND_MASK, 1'b0, SRC_BITS);
        chk_rd(OFS_STATUS, 1'b0, bk | 16'h0004);
        pulse(13'h01FF);
        chk_rd(OFS_STATUS, 1'b0, bk | SRC_BITS);
        chk_irq(1'b0);
        cmd(CMD_LOAD_IRQ_MASK, 11'h040, 1'b0);
        chk_irq(1'b1);
        exp_st = bk | SRC_BITS | 16'h0001;
        chk_rd(OFS_STATUS, 1'b0, exp_st);
        // per-source acknowledges
        clr_step(CMD_ACK_IRQ, 13'h0000, 11'h002, 16'h0000);
        clr_step(CMD_ACK_IRQ, 13'h0000, 11'h020, 16'h0020);
        clr_step(CMD_ACK_IRQ, 13'h0200, 11'h000, 16'h0004);
        clr_step(CMD_ACK_IRQ, 13'h0400, 11'h000, 16'h0010);
        clr_step(CMD_ACK_IRQ, 13'h0800, 11'h000, 16'h0080);
        clr_step(CMD_ACK_IRQ, 13'h1000, 11'h000, 16'h0100);
        clr_step(CMD_ACK_IRQ, 13'h0000, 11'h600, 16'h0600);
        // latch sets again while the software flag stays enabled
        clr_step(CMD_ACK_IRQ, 13'h0000, 11'h001, 16'h0000);
        chk_irq(1'b1);
        clr_step(CMD_ACK_IRQ, 13'h0000, 11'h040, 16'h0040);
        chk_irq(1'b0);
        clr_step(CMD_ACK_IRQ, 13'h0000, 11'h001, 16'h0001);
        clr_step(CMD_GLOBAL_RST, 13'h0000, 11'h040, 16'h0000);
        clr_step(CMD_GLOBAL_RST, 13'h0000, 11'h000, 16'h0002);
        // auto-clearing view wipes the interrupt mask
        cmd(CMD_LOAD_IRQ_MASK, 11'h7F6, 1'b0);
        chk_rd(OFS_IRQ_MASK, 1'b0, SRC_BITS);
        chk_rd(OFS_AUTO_VIEW, 1'b0, bk);
        chk_rd(OFS_IRQ_MASK, 1'b0, 16'h0000);
        // separate bank selections per port
        cmd(CMD_SEL_BANK, 11'h002, 1'b1);
        chk_rd(OFS_STATUS, 1'b1, 16'h4000);
        chk_rd(OFS_STATUS, 1'b0, bk);
        chk_rd(OFS_IND_MASK, 1'b1, 16'h0000);
        conclude();
    end
endmodule
